//--- rtl/ext_bus_mux.sv
// external bus multiplexer, address decoder and internal RAM
`default_nettype none
module ext_bus_mux (
  input wire logic clock_i, // oscillator input clock
  input wire logic reset_i, // async reset, active high
  input wire logic byte_mode_i, // high selects 8-bit bus
  input wire ext_bus_pkg::req_t req_i, // access request
  input wire logic [15:0] direct_page_base_i, // direct page base
  input wire logic [1:0] owner_i, // current bus owner
  input wire logic [7:0] mid_i, // middle pins input
  input wire logic [7:0] high_i, // high pins input
  output logic busy_o, // access in progress
  output logic done_o, // access finished pulse
  output logic [15:0] rdata_o, // read data
  output ext_bus_pkg::target_t target_o, // decoded target
  output logic periph_sel_o, // peripheral register pulse
  output logic dmareg_sel_o, // DMA register pulse
  output logic vector_fetch_o, // vector area access pulse
  output logic [15:0] int_addr_o, // bank-zero address of internal access
  output logic half_clock_o, // half-rate clock
  output logic [7:0] dram_mux_address_o, // low address pins
  output ext_bus_pkg::pins_t pins_o, // multiplexed pins
  output logic [1:0] bus_owner_code_o // bus owner code
);
  // ==========================================================
  // state
  typedef struct packed {
    // sequencing
    ext_bus_pkg::bus_state_t st;
    logic busy;
    logic done;
    // results and pulses towards the core
    logic [15:0] rdata;
    ext_bus_pkg::target_t target;
    logic periph_sel;
    logic dmareg_sel;
    logic vector_fetch;
    logic [15:0] int_addr;
    // pin side
    logic half_clock;
    logic [7:0] low;
    ext_bus_pkg::pins_t pins;
    logic [1:0] owner;
    // latched request
    logic [23:0] addr;
    logic [15:0] wdata;
    logic write;
    logic dram;
  } state_t;

  // ==========================================================
  // registered state and decode nets
  state_t s;
  state_t next_s;
  logic [7:0] iram [ext_bus_pkg::IRAM_BYTES];
  logic [23:0] eff_addr;
  logic [15:0] ofs;
  logic [ext_bus_pkg::IRAM_AW-1:0] iram_idx;
  logic iram_we;
  ext_bus_pkg::target_t dec;

  // ==========================================================
  // address formation and decode
  // internal regions of bank zero, one comparator pair each; the vector area
  // is left out because nothing on chip can answer a fetch there
  localparam int REGION_PERIPH = 0;
  localparam int REGION_IRAM = 1;
  localparam int REGION_DMAREG = 2;
  localparam int REGION_COUNT = 3;
  localparam logic [15:0] REGION_LO [REGION_COUNT] = '{
    ext_bus_pkg::PERIPH_LO,
    ext_bus_pkg::IRAM_LO,
    ext_bus_pkg::DMAREG_LO
  };
  localparam logic [15:0] REGION_HI [REGION_COUNT] = '{
    ext_bus_pkg::PERIPH_HI,
    ext_bus_pkg::IRAM_HI,
    ext_bus_pkg::DMAREG_HI
  };
  logic [REGION_COUNT-1:0] region_hit;
  logic bank_zero;
  logic vector_hit;

  always_comb begin
    // direct page window; the sum wraps inside bank zero on purpose
    if (req_i.direct_page) begin
      eff_addr = {ext_bus_pkg::BANK_ZERO,
        16'(direct_page_base_i + {8'h00, req_i.addr[7:0]})};
    end else begin
      eff_addr = req_i.addr;
    end
    ofs = eff_addr[15:0];
  end

  // only bank zero holds internal resources
  assign bank_zero = (eff_addr[23:16] == ext_bus_pkg::BANK_ZERO);

  // vector area is flagged, yet served off chip
  assign vector_hit = bank_zero
    && (ofs >= ext_bus_pkg::VECTOR_LO)
    && (ofs <= ext_bus_pkg::VECTOR_HI);

  for (genvar g = 0; g < REGION_COUNT; g++) begin : g_region
    assign region_hit[g] = bank_zero && (ofs >= REGION_LO[g]) && (ofs <= REGION_HI[g]);
  end

  always_comb begin
    if (region_hit[REGION_PERIPH]) begin
      dec = ext_bus_pkg::TGT_PERIPH;
    end else if (region_hit[REGION_IRAM]) begin
      dec = ext_bus_pkg::TGT_IRAM;
    end else if (region_hit[REGION_DMAREG]) begin
      dec = ext_bus_pkg::TGT_DMAREG;
    end else begin
      // other banks and unmapped bank-zero space go out
      dec = ext_bus_pkg::TGT_EXT;
    end
    iram_idx = ext_bus_pkg::IRAM_AW'(ofs - ext_bus_pkg::IRAM_LO);
  end

  // ==========================================================
  // next state
  // cycle walk of an external access, counted from the taking edge c0:
  //   c1  address out with strobe high; dram puts the row on the low pins
  //   c2  dram only: column on the low pins, strobe still high
  //   then strobe low for one cycle while the data lanes turn around
  //   then strobe high again, read data captured, done pulse, busy low
  // so done follows the take by three cycles, four for dram
  // a request that comes while busy is dropped without notice: the core
  // side waits for done before it asks again
  // internal targets answer after one cycle and may follow each other
  // on every clock
  always_comb begin
    next_s = s;
    iram_we = 1'b0;
    next_s.half_clock = ~s.half_clock;
    next_s.owner = owner_i;
    // the code is only echoed: arbitration lives outside, so a refresh or
    // hold owner does not stall an access already under way
    next_s.done = 1'b0;
    next_s.periph_sel = 1'b0;
    next_s.dmareg_sel = 1'b0;
    next_s.vector_fetch = 1'b0;
    case (s.st)
      ext_bus_pkg::ST_IDLE: begin
        next_s.pins.strobe_n = 1'b1;
        next_s.pins.mid_oe = 1'b0;
        next_s.pins.high_oe = 1'b0;
        if (req_i.valid) begin
          next_s.target = dec;
          next_s.addr = eff_addr;
          next_s.wdata = req_i.wdata;
          next_s.write = req_i.write;
          next_s.dram = req_i.dram;
          next_s.vector_fetch = vector_hit;
          if (dec == ext_bus_pkg::TGT_EXT) begin
            next_s.busy = 1'b1;
            // row first on dram access, plain address otherwise
            if (req_i.dram) begin
              next_s.st = ext_bus_pkg::ST_ROW;
              next_s.low = eff_addr[15:8];
            end else begin
              next_s.st = ext_bus_pkg::ST_ADDR;
              next_s.low = eff_addr[7:0];
            end
            // address on middle pins while strobe high
            next_s.pins.mid_o = eff_addr[15:8];
            next_s.pins.high_o = eff_addr[23:16];
            next_s.pins.mid_oe = 1'b1;
            next_s.pins.high_oe = 1'b1;
          end else begin
            next_s.done = 1'b1;
            next_s.int_addr = ofs;
            next_s.periph_sel = (dec == ext_bus_pkg::TGT_PERIPH);
            next_s.dmareg_sel = (dec == ext_bus_pkg::TGT_DMAREG);
            if (dec == ext_bus_pkg::TGT_IRAM) begin
              iram_we = req_i.write;
              next_s.rdata = {8'h00, iram[iram_idx]};
            end
          end
        end
      end

      ext_bus_pkg::ST_ROW: begin
        // column follows row
        // the row stands a full cycle before the column so the far side can latch it
        next_s.low = s.addr[7:0];
        next_s.st = ext_bus_pkg::ST_COL;
      end

      ext_bus_pkg::ST_ADDR, ext_bus_pkg::ST_COL: begin
        // data phase only with strobe low
        next_s.pins.strobe_n = 1'b0;
        next_s.st = ext_bus_pkg::ST_DATA;
        // low data byte on high pins
        next_s.pins.high_o = s.wdata[7:0];
        next_s.pins.high_oe = s.write;
        // 16-bit: high data byte on middle pins
        if (!byte_mode_i) begin
          next_s.pins.mid_o = s.wdata[15:8];
          next_s.pins.mid_oe = s.write;
        end else begin
          next_s.pins.mid_o = s.addr[15:8];
          next_s.pins.mid_oe = 1'b1;
        end
      end

      ext_bus_pkg::ST_DATA: begin
        // capture read data before strobe rises
        // no ready input: the far side must answer within one strobe-low cycle
        if (!s.write && byte_mode_i) begin
          // 8-bit: only the high pins carry data
          next_s.rdata = {8'h00, high_i};
        end else if (!s.write) begin
          // 16-bit: middle pins carry the upper byte
          next_s.rdata = {mid_i, high_i};
        end
        next_s.pins.strobe_n = 1'b1;
        next_s.pins.mid_o = s.addr[15:8];
        next_s.pins.high_o = s.addr[23:16];
        next_s.pins.mid_oe = 1'b0;
        next_s.pins.high_oe = 1'b0;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.st = ext_bus_pkg::ST_IDLE;
      end

      default: begin
        next_s.st = ext_bus_pkg::ST_IDLE;
        next_s.busy = 1'b0;
        next_s.pins.strobe_n = 1'b1;
      end
    endcase
    // low pins mirrored into the pin group so the group is complete
    next_s.pins.low_o = next_s.low;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      // strobe idles high and the processor owns the bus out of reset
      s <= '0;
      s.st <= ext_bus_pkg::ST_IDLE;
      s.target <= ext_bus_pkg::TGT_EXT;
      s.pins.strobe_n <= 1'b1;
      s.owner <= ext_bus_pkg::OWNER_CPU;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // internal RAM
  // RAM has no reset; contents are undefined until written
  always_ff @(posedge clock_i) begin
    if (iram_we) begin
      iram[iram_idx] <= req_i.wdata[7:0];
    end
  end

  // ==========================================================
  // outputs
  // every output is read straight off the state register
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign rdata_o = s.rdata;
  assign target_o = s.target;
  assign periph_sel_o = s.periph_sel;
  assign dmareg_sel_o = s.dmareg_sel;
  assign vector_fetch_o = s.vector_fetch;
  assign int_addr_o = s.int_addr;

  // pin side
  assign half_clock_o = s.half_clock;
  assign dram_mux_address_o = s.low;
  assign pins_o = s.pins;
  assign bus_owner_code_o = s.owner;
endmodule
`default_nettype wire

//--- rtl/ext_bus_pkg.sv
// shared constants and carrier types for the external bus interface
`default_nettype none
package ext_bus_pkg;
  // ==========================================================
  // address map
  localparam logic [7:0] BANK_ZERO = 8'h00;
  localparam logic [15:0] PERIPH_LO = 16'h0000;
  localparam logic [15:0] PERIPH_HI = 16'h007F;
  localparam logic [15:0] IRAM_LO = 16'h0080;
  localparam logic [15:0] IRAM_HI = 16'h027F;
  localparam logic [15:0] DMAREG_LO = 16'h1FC0;
  localparam logic [15:0] DMAREG_HI = 16'h1FFF;
  localparam logic [15:0] VECTOR_LO = 16'hFFCE;
  localparam logic [15:0] VECTOR_HI = 16'hFFFF;
  localparam int IRAM_BYTES = 512;
  localparam int IRAM_AW = 9;

  // ==========================================================
  // bus owner codes
  localparam logic [1:0] OWNER_REFRESH = 2'h0;
  localparam logic [1:0] OWNER_HOLD = 2'h1;
  localparam logic [1:0] OWNER_DMA = 2'h2;
  localparam logic [1:0] OWNER_CPU = 2'h3;

  // decode target of an access
  typedef enum logic [3:0] {
    TGT_PERIPH = 4'h1,
    TGT_DMAREG = 4'h2,
    TGT_IRAM = 4'h4,
    TGT_EXT = 4'h8
  } target_t;

  // external cycle state, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ROW = 5'h04,
    ST_COL = 5'h08,
    ST_DATA = 5'h10
  } bus_state_t;

  // access request from the core side
  typedef struct packed {
    logic valid;
    logic write;
    logic dram;
    logic direct_page;
    logic [23:0] addr;
    logic [15:0] wdata;
  } req_t;

  // multiplexed pin group: output value per lane, enable on the mid and high lanes only
  typedef struct packed {
    logic [7:0] low_o;
    logic [7:0] mid_o;
    logic mid_oe;
    logic [7:0] high_o;
    logic high_oe;
    logic strobe_n;
  } pins_t;
endpackage
`default_nettype wire

//--- sim/ext_bus_properties.sv
// checker for the external bus multiplexer
`default_nettype none
module ext_bus_properties (
  input wire logic clock_i, // clock
  input wire logic reset_i, // reset
  input wire logic byte_mode_i, // width pin
  input wire ext_bus_pkg::req_t req_i, // request
  input wire logic [1:0] owner_i, // owner source
  input wire logic busy_o, // busy
  input wire logic done_o, // done
  input wire ext_bus_pkg::target_t target_o, // target
  input wire logic periph_sel_o, // peripheral pulse
  input wire logic half_clock_o, // half clock
  input wire logic [7:0] dram_mux_address_o, // low pins
  input wire ext_bus_pkg::pins_t pins_o, // pins
  input wire logic [1:0] bus_owner_code_o // owner code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic take;
  logic [15:0] a;
  // direct page requests are left out, their address is rebuilt inside
  assign take = req_i.valid && !busy_o && !done_o && !req_i.direct_page;
  assign a = req_i.addr[15:0];
  chk_half_rate: assert property (!$past(reset_i) |-> half_clock_o != $past(half_clock_o))
    else $error("half clock stuck");
  chk_owner_echo: assert property (!$past(reset_i) |-> bus_owner_code_o == $past(owner_i))
    else $error("owner code wrong");
  chk_addr_phase: assert property ($rose(busy_o) && !$past(req_i.direct_page) |->
    pins_o.strobe_n && pins_o.high_oe && pins_o.mid_oe
    && {pins_o.high_o, pins_o.mid_o} == $past(req_i.addr[23:8]))
    else $error("address phase wrong");
  chk_dmareg_sel: assert property (take && req_i.addr[23:16] == 8'h00 && a >= 16'h1FC0
    && a <= 16'h1FFF |-> ##1 done_o && target_o == ext_bus_pkg::TGT_DMAREG && pins_o.strobe_n)
    else $error("DMA register decode wrong");
  chk_row_col: assert property ($rose(busy_o) && $past(req_i.dram) |->
    dram_mux_address_o == $past(a[15:8]) ##1 dram_mux_address_o == $past(a[7:0], 2))
    else $error("row or column wrong");
  chk_byte_lane: assert property (byte_mode_i && busy_o |-> pins_o.mid_oe)
    else $error("mid pins released in byte mode");
  chk_strobe_short: assert property ($fell(pins_o.strobe_n) |-> busy_o ##1 pins_o.strobe_n && done_o)
    else $error("strobe phase wrong");
  chk_periph_sel: assert property (take && req_i.addr <= 24'h7F |->
    ##1 done_o && periph_sel_o && target_o == ext_bus_pkg::TGT_PERIPH && pins_o.strobe_n)
    else $error("peripheral decode wrong");
  chk_ext_route: assert property (take && req_i.addr[23:16] != 8'h00 |->
    ##1 busy_o ##[2:3] done_o && target_o == ext_bus_pkg::TGT_EXT)
    else $error("external route wrong");
endmodule
bind ext_bus_mux ext_bus_properties ext_bus_properties_inst (.clock_i, .reset_i, .byte_mode_i,
  .req_i, .owner_i, .busy_o, .done_o, .target_o, .periph_sel_o, .half_clock_o,
  .dram_mux_address_o, .pins_o, .bus_owner_code_o);
`default_nettype wire

//--- sim/ext_mem_model.sv
// behavioural external memory on the multiplexed bus
`default_nettype none
module ext_mem_model (
  input wire logic clock_i, // clock
  input wire logic byte_mode_i, // high: 8-bit bus
  input wire logic [7:0] low_i, // low address pins
  input wire ext_bus_pkg::pins_t pins_i, // multiplexed pins
  output logic [7:0] mid_o, // middle pins to device
  output logic [7:0] high_o // high pins to device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [7:0] idx;
  logic [7:0] junk;
  logic rd;
  initial begin
    junk = 8'hA5;
    for (int i = 0; i < 256; i++) mem[i] = {~i[7:0], i[7:0]};
  end
  // data only while strobe low, mid lane only on 16-bit
  assign rd = !pins_i.strobe_n && !pins_i.high_oe;
  // released lanes show a moving pattern so stale data cannot pass
  assign high_o = rd ? mem[idx][7:0] : junk;
  assign mid_o = (rd && !byte_mode_i) ? mem[idx][15:8] : ~junk;
  // last low-pin value before strobe picks the word
  always @(posedge clock_i) begin
    junk <= junk + 8'h01;
    if (pins_i.strobe_n) idx <= low_i;
    else if (pins_i.high_oe) mem[idx] <= {byte_mode_i ? mem[idx][15:8] : pins_i.mid_o, pins_i.high_o};
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the external bus multiplexer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, reset_i, byte_mode_i;
  ext_bus_pkg::req_t req_i;
  logic [15:0] direct_page_base_i, rdata_o;
  logic [1:0] owner_i, bus_owner_code_o;
  logic [7:0] mid_i, high_i, low;
  logic busy_o, done_o, periph_sel_o, dmareg_sel_o, vector_fetch_o;
  logic [15:0] int_addr_o;
  logic [2:0] sel;
  ext_bus_pkg::target_t target_o;
  ext_bus_pkg::pins_t pins_o;
  int errors = 0;
  int checks = 0;
  int lat;
  logic [23:0] map_a [10] = '{24'h0, 24'h7F, 24'h80, 24'h27F, 24'h280, 24'h1FBF, 24'h1FC0,
    24'h1FFF, 24'h10050, 24'hFF0000};
  logic [3:0] map_t [10] = '{4'h1, 4'h1, 4'h4, 4'h4, 4'h8, 4'h8, 4'h2, 4'h2, 4'h8, 4'h8};
  ext_bus_mux ext_bus_mux_inst (.clock_i, .reset_i, .byte_mode_i, .req_i, .direct_page_base_i,
    .owner_i, .mid_i, .high_i, .busy_o, .done_o, .rdata_o, .target_o, .periph_sel_o,
    .dmareg_sel_o, .vector_fetch_o, .int_addr_o, .half_clock_o(),
    .dram_mux_address_o(low), .pins_o, .bus_owner_code_o);
  ext_mem_model ext_mem_model_inst (.clock_i, .byte_mode_i, .low_i(low), .pins_i(pins_o),
    .mid_o(mid_i), .high_o(high_i));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // lat counts clocks from take to done, minus one
  task automatic acc(input logic w, input logic dr, input logic dp, input logic [23:0] a,
      input logic [15:0] d);
    req_i <= '{1'b1, w, dr, dp, a, d};
    @(posedge clock_i);
    req_i.valid <= 1'b0;
    lat = 0;
    @(negedge clock_i);
    sel = {vector_fetch_o, dmareg_sel_o, periph_sel_o};
    while (done_o !== 1'b1 && lat < 8) begin
      @(negedge clock_i);
      lat++;
    end
    @(posedge clock_i);
  endtask
  task automatic t_map();
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, 1'b0, 1'b0, map_a[i], 16'h0);
      check(16'(target_o), 16'(map_t[i]));
      check(16'(lat), (map_t[i] == 4'h8) ? 16'h2 : 16'h0);
      check(16'(sel[1:0]), 16'(map_t[i][1:0]));
      if (map_t[i] != 4'h8) check(int_addr_o, map_a[i][15:0]);
    end
  endtask
  task automatic t_iram();
    acc(1'b1, 1'b0, 1'b0, 24'h80, 16'h12C3);
    acc(1'b1, 1'b0, 1'b0, 24'h27F, 16'h3456);
    acc(1'b0, 1'b0, 1'b0, 24'h80, 16'h0);
    check(rdata_o, 16'h00C3);
    acc(1'b0, 1'b0, 1'b0, 24'h27F, 16'h0);
    check(rdata_o, 16'h0056);
  endtask
  task automatic t_ext();
    acc(1'b1, 1'b0, 1'b0, 24'h123456, 16'hBEEF);
    acc(1'b0, 1'b0, 1'b0, 24'h7F0056, 16'h0);
    check(rdata_o, 16'hBEEF);
    check(16'(sel[2]), 16'h0);
    acc(1'b0, 1'b0, 1'b0, 24'hFFCE, 16'h0);
    check(rdata_o, 16'h31CE);
    check(16'(sel[2]), 16'h1);
    byte_mode_i <= 1'b1;
    acc(1'b1, 1'b0, 1'b0, 24'h20011, 16'h77AA);
    acc(1'b0, 1'b0, 1'b0, 24'h20011, 16'h0);
    check(rdata_o, 16'h00AA);
    byte_mode_i <= 1'b0;
    acc(1'b0, 1'b0, 1'b0, 24'h20011, 16'h0);
    check(rdata_o, 16'hEEAA);
  endtask
  task automatic t_dram_dp();
    acc(1'b0, 1'b1, 1'b0, 24'h4C7, 16'h0);
    check(rdata_o, 16'h38C7);
    check(16'(lat), 16'h3);
    direct_page_base_i <= 16'h1F00;
    acc(1'b0, 1'b0, 1'b1, 24'hC5, 16'h0);
    check(16'(target_o), 16'h2);
    direct_page_base_i <= 16'h0100;
    acc(1'b1, 1'b0, 1'b1, 24'h80, 16'h5A);
    acc(1'b0, 1'b0, 1'b0, 24'h180, 16'h0);
    check(rdata_o, 16'h005A);
  endtask
  task automatic t_owner();
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      owner_i <= 2'(i);
      @(posedge clock_i);
      @(negedge clock_i);
      check(16'(bus_owner_code_o), 16'(i));
    end
  endtask
  initial begin
    reset_i = 1'b1;
    byte_mode_i = 1'b0;
    owner_i = 2'h3;
    direct_page_base_i = 16'h0;
    req_i = '0;
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    t_map();
    t_iram();
    t_ext();
    t_dram_dp();
    t_owner();
    give_verdict();
  end
  // 24 accesses of at most five clocks; about twenty times that margin
  initial begin
    repeat (2500) @(posedge clock_i);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
